// ===== core/ast_pkg.sv
// Shared constants, types and helpers for the rate and side-tone control block
package ast_pkg;

  // ---------------------------------------------------------------
  // Register addresses on the link command slot
  // ---------------------------------------------------------------
  localparam logic [6:0] AST_ADDR_BEEP_VOL   = 7'h0a;
  localparam logic [6:0] AST_ADDR_PHONE_VOL  = 7'h0c;
  localparam logic [6:0] AST_ADDR_LINE_VOL   = 7'h10;
  localparam logic [6:0] AST_ADDR_AUX_VOL    = 7'h12;
  localparam logic [6:0] AST_ADDR_SIDETONE   = 7'h14;
  localparam logic [6:0] AST_ADDR_DAC_VOL    = 7'h18;
  localparam logic [6:0] AST_ADDR_EXT_AUDIO  = 7'h2a;
  localparam logic [6:0] AST_ADDR_PLAY_RATE  = 7'h2c;
  localparam logic [6:0] AST_ADDR_AUX_RATE   = 7'h2e;
  localparam logic [6:0] AST_ADDR_REC_RATE   = 7'h32;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int AST_MIC_MUTE_BIT  = 15;
  localparam int AST_MIC_GAIN_LSB  = 12;
  localparam int AST_ROUTE_LSB     = 10;
  localparam int AST_LVL_GAIN_LSB  = 7;
  localparam int AST_VRA_BIT       = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic        AST_MIC_MUTE_RST = 1'b1;
  localparam logic [2:0]  AST_GAIN_RST     = 3'h2;
  localparam logic [1:0]  AST_ROUTE_RST    = 2'h3;
  localparam logic        AST_VRA_RST      = 1'b0;
  localparam logic [15:0] AST_RATE_RST     = 16'hbb80;
  localparam logic [15:0] AST_MIX_VOL_RST  = 16'h0000;

  // ---------------------------------------------------------------
  // Rates
  // ---------------------------------------------------------------
  localparam logic [15:0] AST_FRAME_RATE = 16'hbb80;
  localparam int          AST_NUM_RATES  = 9;
  localparam logic [15:0] AST_RATES [AST_NUM_RATES] = '{
    16'h1f40, 16'h2b11, 16'h2ee0, 16'h3e80, 16'h5622,
    16'h5dc0, 16'h7d00, 16'hac44, 16'hbb80
  };
  localparam int AST_NUM_MIX = 5;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    AST_ROUTE_STEREO = 2'b00,
    AST_ROUTE_RIGHT  = 2'b01,
    AST_ROUTE_LEFT   = 2'b10,
    AST_ROUTE_MUTE   = 2'b11
  } ast_route_e;

  typedef struct packed {
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] data;
  } ast_cmd_s;

  typedef struct packed {
    logic       mic_en;
    logic [2:0] mic_gain;
    logic       lvl_left_en;
    logic       lvl_right_en;
    logic [2:0] lvl_gain;
  } ast_sidetone_s;

  // Nearest supported rate; ties go to the lower rate
  function automatic logic [15:0] ast_nearest(input logic [15:0] code);
    logic [15:0] best;
    logic [16:0] best_d;
    logic [16:0] d;
    best   = AST_RATES[0];
    best_d = 17'h1ffff;
    for (int i = 0; i < AST_NUM_RATES; i++) begin
      d = (code >= AST_RATES[i]) ? {1'b0, code - AST_RATES[i]} : {1'b0, AST_RATES[i] - code};
      if (d < best_d) begin
        best_d = d;
        best   = AST_RATES[i];
      end
    end
    return best;
  endfunction

endpackage

// ===== core/ast_sync.sv
// Two-stage synchroniser for levels and toggles
module ast_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// ===== core/ast_frame_pacer.sv
// Per-stream frame pacer: flags which link frames carry a sample
module ast_frame_pacer
  import ast_pkg::*;
(
  // Link clock and reset
  input  wire logic        link_clk_i,
  input  wire logic        rst_i,
  // Frame and rate
  input  wire logic        frame_i,
  input  wire logic [15:0] rate_i,
  output logic             slot_valid_o
);
  logic [16:0] acc_q;
  logic [16:0] sum;

  // Rate never exceeds the frame rate, so the sum fits 17 bits
  assign sum = acc_q + {1'b0, rate_i};

  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      acc_q        <= '0;
      slot_valid_o <= 1'b0;
    end else if (frame_i) begin
      if (sum >= {1'b0, AST_FRAME_RATE}) begin
        acc_q        <= sum - {1'b0, AST_FRAME_RATE};
        slot_valid_o <= 1'b1;
      end else begin
        acc_q        <= sum;
        slot_valid_o <= 1'b0;
      end
    end
  end
endmodule

// ===== core/ast_audio_rate_sidetone_ctrl.sv
// Variable-rate and side-tone control registers with link-side frame pacing
//
// Contract
// - Mic side-tone select bit 15: 0 routes to headphone mixer, 1 mutes; reset 1.
// - Mic side-tone gain: 000 is +6dB, 3dB steps to 111 -15dB; reset 010.
// - Level side-tone route bits 11:10: 11 mute, 10 left, 01 right, 00 stereo.
// - Level side-tone gain bits 9:7, same encoding as mic gain, reset 010.
// - Side-tone feeds only the headphone mixer, from mic or level path, no boost.
// - Variable-rate enable clear: playback and record run at 48kHz.
// - Enable set and converter on: use rate codes at 2Ch, 32h, 2Eh.
// - Link frames keep running at 48k per second at any rate.
// - Below 48kHz some frames carry no sample, giving the average rate.
// - Playback rate code is the rate in Hz; reset BB80h.
// - Unlisted rate codes run at the nearest supported rate.
// - Record rate uses playback encoding; writes ignored while record off.
// - Auxiliary output rate uses playback encoding, reset BB80h.
// - The three stream rates are fully independent of one another.
// - Each mixer input volume and mute comes from its source register.
module ast_audio_rate_sidetone_ctrl
  import ast_pkg::*;
(
  // System clock and reset
  input  wire logic                              sys_clk_i,
  input  wire logic                              reset_i,
  // Link side, on the link clock
  input  wire logic                              link_clk_i,
  input  wire logic                              link_frame_i,
  input  wire logic                              link_cmd_valid_i,
  input  wire ast_pkg::ast_cmd_s                 link_cmd_i,
  output logic                                   link_rd_valid_o,
  output logic                     [15:0]        link_rd_data_o,
  output logic                                   link_play_valid_o,
  output logic                                   link_rec_valid_o,
  output logic                                   link_aux_valid_o,
  // Converter enables from power management
  input  wire logic                              dac_enable_i,
  input  wire logic                              adc_enable_i,
  input  wire logic                              aux_enable_i,
  // Mixer and converter controls
  output ast_pkg::ast_sidetone_s                 sidetone_o,
  output logic [ast_pkg::AST_NUM_MIX-1:0][15:0]  mixer_vol_o,
  output logic                     [15:0]        play_rate_o,
  output logic                     [15:0]        rec_rate_o,
  output logic                     [15:0]        aux_rate_o
);

  // ---------------------------------------------------------------
  // Link-domain reset
  // ---------------------------------------------------------------
  logic link_rst;

  ast_sync #(.W(1)) u_link_rst (
    .clk_i (link_clk_i),
    .rst_i (1'b0),
    .d_i   (reset_i),
    .q_o   (link_rst)
  );

  // ---------------------------------------------------------------
  // Link domain: command capture
  // ---------------------------------------------------------------
  // Held word stays stable for a whole frame; sys samples it after the toggle
  ast_cmd_s cmd_hold_q;
  logic     cmd_tgl_q;

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      cmd_hold_q <= '0;
      cmd_tgl_q  <= 1'b0;
    end else if (link_cmd_valid_i) begin
      cmd_hold_q <= link_cmd_i;
      cmd_tgl_q  <= ~cmd_tgl_q;
    end
  end

  // ---------------------------------------------------------------
  // Sys domain: command arrival
  // ---------------------------------------------------------------
  logic     cmd_tgl_s;
  logic     cmd_tgl_seen_q;
  logic     cmd_evt;
  ast_cmd_s cmd;

  ast_sync #(.W(1)) u_cmd_sync (
    .clk_i (sys_clk_i),
    .rst_i (reset_i),
    .d_i   (cmd_tgl_q),
    .q_o   (cmd_tgl_s)
  );

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cmd_tgl_seen_q <= 1'b0;
    end else begin
      cmd_tgl_seen_q <= cmd_tgl_s;
    end
  end

  assign cmd_evt = cmd_tgl_s ^ cmd_tgl_seen_q;
  assign cmd     = cmd_hold_q;

  logic wr_evt;
  logic rd_evt;
  assign wr_evt = cmd_evt & ~cmd.rd;
  assign rd_evt = cmd_evt & cmd.rd;

  // ---------------------------------------------------------------
  // Side-tone register
  // ---------------------------------------------------------------
  logic       mic_sidetone_mute_q;
  logic [2:0] mic_sidetone_gain_q;
  logic [1:0] level_ctrl_sidetone_route_q;
  logic [2:0] level_ctrl_sidetone_gain_q;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mic_sidetone_mute_q         <= AST_MIC_MUTE_RST;
      mic_sidetone_gain_q         <= AST_GAIN_RST;
      level_ctrl_sidetone_route_q <= AST_ROUTE_RST;
      level_ctrl_sidetone_gain_q  <= AST_GAIN_RST;
    end else if (wr_evt && cmd.addr == AST_ADDR_SIDETONE) begin
      mic_sidetone_mute_q         <= cmd.data[AST_MIC_MUTE_BIT];
      mic_sidetone_gain_q         <= cmd.data[AST_MIC_GAIN_LSB +: 3];
      level_ctrl_sidetone_route_q <= cmd.data[AST_ROUTE_LSB +: 2];
      level_ctrl_sidetone_gain_q  <= cmd.data[AST_LVL_GAIN_LSB +: 3];
    end
  end

  // Gain codes pass unchanged; the analogue stage applies the dB steps
  ast_route_e route;
  assign route = ast_route_e'(level_ctrl_sidetone_route_q);

  // Only a headphone-mixer control set exists; there is no boost term here
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sidetone_o <= '0;
    end else begin
      sidetone_o.mic_en   <= ~mic_sidetone_mute_q;
      sidetone_o.mic_gain <= mic_sidetone_gain_q;
      sidetone_o.lvl_gain <= level_ctrl_sidetone_gain_q;
      unique case (route)
        AST_ROUTE_STEREO: begin
          sidetone_o.lvl_left_en  <= 1'b1;
          sidetone_o.lvl_right_en <= 1'b1;
        end
        AST_ROUTE_RIGHT: begin
          sidetone_o.lvl_left_en  <= 1'b0;
          sidetone_o.lvl_right_en <= 1'b1;
        end
        AST_ROUTE_LEFT: begin
          sidetone_o.lvl_left_en  <= 1'b1;
          sidetone_o.lvl_right_en <= 1'b0;
        end
        AST_ROUTE_MUTE: begin
          sidetone_o.lvl_left_en  <= 1'b0;
          sidetone_o.lvl_right_en <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mixer input source registers
  // ---------------------------------------------------------------
  localparam logic [6:0] MIX_ADDR [AST_NUM_MIX] = '{
    AST_ADDR_BEEP_VOL, AST_ADDR_PHONE_VOL, AST_ADDR_LINE_VOL,
    AST_ADDR_AUX_VOL, AST_ADDR_DAC_VOL
  };

  for (genvar g = 0; g < AST_NUM_MIX; g++) begin : g_mix
    always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
        mixer_vol_o[g] <= AST_MIX_VOL_RST;
      end else if (wr_evt && cmd.addr == MIX_ADDR[g]) begin
        mixer_vol_o[g] <= cmd.data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Variable-rate enable and rate codes
  // ---------------------------------------------------------------
  logic        variable_rate_enable_q;
  logic [15:0] playback_rate_code_q;
  logic [15:0] record_rate_code_q;
  logic [15:0] aux_out_rate_code_q;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      variable_rate_enable_q <= AST_VRA_RST;
    end else if (wr_evt && cmd.addr == AST_ADDR_EXT_AUDIO) begin
      variable_rate_enable_q <= cmd.data[AST_VRA_BIT];
    end
  end

  // Separate registers per stream, so any rate mix is legal
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      playback_rate_code_q <= AST_RATE_RST;
    end else if (wr_evt && cmd.addr == AST_ADDR_PLAY_RATE) begin
      playback_rate_code_q <= cmd.data;
    end
  end

  // Controller must power up the record path first, else the write is lost
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      record_rate_code_q <= AST_RATE_RST;
    end else if (wr_evt && cmd.addr == AST_ADDR_REC_RATE && adc_enable_i) begin
      record_rate_code_q <= cmd.data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      aux_out_rate_code_q <= AST_RATE_RST;
    end else if (wr_evt && cmd.addr == AST_ADDR_AUX_RATE) begin
      aux_out_rate_code_q <= cmd.data;
    end
  end

  // ---------------------------------------------------------------
  // Effective converter rates
  // ---------------------------------------------------------------
  logic [15:0] play_rate_d;
  logic [15:0] rec_rate_d;
  logic [15:0] aux_rate_d;

  always_comb begin
    play_rate_d = AST_FRAME_RATE;
    rec_rate_d  = AST_FRAME_RATE;
    aux_rate_d  = AST_FRAME_RATE;
    if (variable_rate_enable_q && dac_enable_i) begin
      play_rate_d = ast_nearest(playback_rate_code_q);
    end
    if (variable_rate_enable_q && adc_enable_i) begin
      rec_rate_d = ast_nearest(record_rate_code_q);
    end
    if (variable_rate_enable_q && aux_enable_i) begin
      aux_rate_d = ast_nearest(aux_out_rate_code_q);
    end
  end

  logic rate_tgl_q;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      play_rate_o <= AST_RATE_RST;
      rec_rate_o  <= AST_RATE_RST;
      aux_rate_o  <= AST_RATE_RST;
      rate_tgl_q  <= 1'b0;
    end else begin
      play_rate_o <= play_rate_d;
      rec_rate_o  <= rec_rate_d;
      aux_rate_o  <= aux_rate_d;
      if (play_rate_d != play_rate_o || rec_rate_d != rec_rate_o
          || aux_rate_d != aux_rate_o) begin
        rate_tgl_q <= ~rate_tgl_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read-back
  // ---------------------------------------------------------------
  logic [15:0] rd_word;
  logic [15:0] rd_data_q;
  logic        rd_tgl_q;

  always_comb begin
    rd_word = 16'h0000;
    unique case (cmd.addr)
      AST_ADDR_SIDETONE: begin
        rd_word[AST_MIC_MUTE_BIT]         = mic_sidetone_mute_q;
        rd_word[AST_MIC_GAIN_LSB +: 3]    = mic_sidetone_gain_q;
        rd_word[AST_ROUTE_LSB +: 2]       = level_ctrl_sidetone_route_q;
        rd_word[AST_LVL_GAIN_LSB +: 3]    = level_ctrl_sidetone_gain_q;
      end
      AST_ADDR_EXT_AUDIO: rd_word[AST_VRA_BIT] = variable_rate_enable_q;
      AST_ADDR_PLAY_RATE: rd_word = playback_rate_code_q;
      AST_ADDR_REC_RATE:  rd_word = record_rate_code_q;
      AST_ADDR_AUX_RATE:  rd_word = aux_out_rate_code_q;
      AST_ADDR_BEEP_VOL:  rd_word = mixer_vol_o[0];
      AST_ADDR_PHONE_VOL: rd_word = mixer_vol_o[1];
      AST_ADDR_LINE_VOL:  rd_word = mixer_vol_o[2];
      AST_ADDR_AUX_VOL:   rd_word = mixer_vol_o[3];
      AST_ADDR_DAC_VOL:   rd_word = mixer_vol_o[4];
      default:            rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rd_data_q <= 16'h0000;
      rd_tgl_q  <= 1'b0;
    end else if (rd_evt) begin
      rd_data_q <= rd_word;
      rd_tgl_q  <= ~rd_tgl_q;
    end
  end

  // ---------------------------------------------------------------
  // Link domain: read answer and rate capture
  // ---------------------------------------------------------------
  logic [1:0] back_tgl_s;
  logic [1:0] back_seen_q;

  ast_sync #(.W(2)) u_back_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst),
    .d_i   ({rate_tgl_q, rd_tgl_q}),
    .q_o   (back_tgl_s)
  );

  logic [15:0] link_play_rate_q;
  logic [15:0] link_rec_rate_q;
  logic [15:0] link_aux_rate_q;

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      back_seen_q     <= 2'h0;
      link_rd_valid_o <= 1'b0;
      link_rd_data_o  <= 16'h0000;
    end else begin
      back_seen_q     <= back_tgl_s;
      link_rd_valid_o <= back_tgl_s[0] ^ back_seen_q[0];
      if (back_tgl_s[0] ^ back_seen_q[0]) begin
        link_rd_data_o <= rd_data_q;
      end
    end
  end

  // Rate words are quasi-static; they settle long before the toggle lands
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      link_play_rate_q <= AST_RATE_RST;
      link_rec_rate_q  <= AST_RATE_RST;
      link_aux_rate_q  <= AST_RATE_RST;
    end else if (back_tgl_s[1] ^ back_seen_q[1]) begin
      link_play_rate_q <= play_rate_o;
      link_rec_rate_q  <= rec_rate_o;
      link_aux_rate_q  <= aux_rate_o;
    end
  end

  // ---------------------------------------------------------------
  // Frame pacing per stream
  // ---------------------------------------------------------------
  // Frames are never suppressed; only the per-stream tags vary
  ast_frame_pacer u_play_pacer (
    .link_clk_i   (link_clk_i),
    .rst_i        (link_rst),
    .frame_i      (link_frame_i),
    .rate_i       (link_play_rate_q),
    .slot_valid_o (link_play_valid_o)
  );

  ast_frame_pacer u_rec_pacer (
    .link_clk_i   (link_clk_i),
    .rst_i        (link_rst),
    .frame_i      (link_frame_i),
    .rate_i       (link_rec_rate_q),
    .slot_valid_o (link_rec_valid_o)
  );

  ast_frame_pacer u_aux_pacer (
    .link_clk_i   (link_clk_i),
    .rst_i        (link_rst),
    .frame_i      (link_frame_i),
    .rate_i       (link_aux_rate_q),
    .slot_valid_o (link_aux_valid_o)
  );

endmodule

// ===== sim/ast_ctrl_checker.sv
// Port-level assertions for the rate and side-tone control block
module ast_ctrl_checker (
  // Clocks and reset
  input wire logic                  sys_clk_i,
  input wire logic                  reset_i,
  input wire logic                  link_clk_i,
  // Watched ports
  input wire logic                  link_frame_i,
  input wire logic                  link_aux_valid_o,
  input wire logic                  dac_enable_i,
  input wire logic                  adc_enable_i,
  input wire ast_pkg::ast_sidetone_s sidetone_o,
  input wire logic [15:0]           play_rate_o,
  input wire logic [15:0]           rec_rate_o,
  input wire logic [15:0]           aux_rate_o
);
  import ast_pkg::*;
  mic_reset_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(reset_i) |=> !sidetone_o.mic_en && sidetone_o.mic_gain == 3'h2)
    else $error("mic side-tone state after reset wrong");
  lvl_reset_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(reset_i) |=> sidetone_o.lvl_gain == 3'h2 && !sidetone_o.lvl_left_en
      && !sidetone_o.lvl_right_en)
    else $error("level side-tone state after reset wrong");
  play_off_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !dac_enable_i [*4] |-> play_rate_o == 16'hbb80)
    else $error("playback rate not 48k with converter off");
  rec_off_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !adc_enable_i [*4] |-> rec_rate_o == 16'hbb80)
    else $error("record rate not 48k with converter off");
  play_near_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    play_rate_o inside {AST_RATES})
    else $error("playback rate not a supported rate");
  rec_near_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    rec_rate_o inside {AST_RATES})
    else $error("record rate not a supported rate");
  tag_hold_a: assert property (@(posedge link_clk_i) disable iff (reset_i)
    !$past(link_frame_i) |-> $stable(link_aux_valid_o))
    else $error("aux tag changed outside a frame");
  full_rate_a: assert property (@(posedge link_clk_i) disable iff (reset_i)
    link_frame_i && aux_rate_o == 16'hbb80 && $past(aux_rate_o, 6) == 16'hbb80
      |=> link_aux_valid_o)
    else $error("aux tag missing at 48k");
endmodule

// ===== sim/ast_link_host.sv
// Controller model on the link: frame strobes and register commands
module ast_link_host (
  // Link clock and enable
  input  wire logic        link_clk_i,
  input  wire logic        run_i,
  // Toward the block
  output logic             frame_o,
  output logic             cmd_valid_o,
  output ast_pkg::ast_cmd_s cmd_o
);
  import ast_pkg::*;
  logic [3:0] slot_q = 4'h0;
  initial begin
    frame_o = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // Frames keep their cadence whatever the rates; cut to 16 bit clocks
  always @(negedge link_clk_i) begin
    slot_q <= slot_q + 4'h1;
    frame_o <= run_i && slot_q == 4'h0;
  end
  // Idle word is inverted so a stale command never reads as fresh
  task automatic send(input logic rd, input logic [6:0] a, input logic [15:0] d);
    @(negedge link_clk_i);
    cmd_o <= {rd, a, d};
    cmd_valid_o <= 1'b1;
    @(negedge link_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o <= ~cmd_o;
    repeat (15) @(negedge link_clk_i);
  endtask
endmodule

// ===== sim/ast_audio_rate_sidetone_ctrl_bench.sv
// Self-checking bench for the rate and side-tone control block
module ast_audio_rate_sidetone_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ast_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic link_clk = 1'b0;
  logic run = 1'b0;
  logic dac_en = 1'b0;
  logic adc_en = 1'b0;
  logic aux_en = 1'b0;
  logic frame, cmd_valid, rd_valid, play_v, rec_v, aux_v;
  logic [15:0] rd_data, play_rate, rec_rate, aux_rate, w;
  ast_cmd_s cmd;
  ast_sidetone_s st;
  logic [AST_NUM_MIX-1:0][15:0] mix;
  logic [6:0] maddr [5] = '{AST_ADDR_BEEP_VOL, AST_ADDR_PHONE_VOL, AST_ADDR_LINE_VOL,
    AST_ADDR_AUX_VOL, AST_ADDR_DAC_VOL};
  logic [15:0] exp_q [$];
  int fails = 0;
  int n_tests = 0;
  int p, r, a;
  always #12.5 sys_clk_i = ~sys_clk_i;
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  ast_audio_rate_sidetone_ctrl dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .link_clk_i(link_clk), .link_frame_i(frame), .link_cmd_valid_i(cmd_valid),
    .link_cmd_i(cmd), .link_rd_valid_o(rd_valid), .link_rd_data_o(rd_data),
    .link_play_valid_o(play_v), .link_rec_valid_o(rec_v), .link_aux_valid_o(aux_v),
    .dac_enable_i(dac_en), .adc_enable_i(adc_en), .aux_enable_i(aux_en),
    .sidetone_o(st), .mixer_vol_o(mix), .play_rate_o(play_rate),
    .rec_rate_o(rec_rate), .aux_rate_o(aux_rate));
  ast_link_host host (.link_clk_i(link_clk), .run_i(run), .frame_o(frame),
    .cmd_valid_o(cmd_valid), .cmd_o(cmd));
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [15:0] d);
    host.send(1'b0, ad, d);
  endtask
  task automatic rd(input logic [6:0] ad, input logic [15:0] e);
    exp_q.push_back(e);
    host.send(1'b1, ad, 16'h0000);
  endtask
  // Read answers stand one link cycle, so look mid-cycle
  always @(negedge link_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("unexpected read answer: expected none seen %h", rd_data);
      end
      else check("read data", exp_q.pop_front(), rd_data);
    end
  end
  function automatic logic [15:0] near(input logic [15:0] c);
    logic [15:0] b;
    b = AST_RATES[0];
    foreach (AST_RATES[i])
      if ((c > AST_RATES[i] ? c - AST_RATES[i] : AST_RATES[i] - c) < (c > b ? c - b : b - c))
        b = AST_RATES[i];
    return b;
  endfunction
  task automatic tags(input int n, input int ep, input int er, input int ea);
    p = 0;
    r = 0;
    a = 0;
    repeat (n) begin
      @(posedge link_clk iff frame === 1'b1);
      @(negedge link_clk);
      p += int'(play_v);
      r += int'(rec_v);
      a += int'(aux_v);
    end
    check("play tags", 16'(ep), 16'(p));
    check("rec tags", 16'(er), 16'(r));
    check("aux tags", 16'(ea), 16'(a));
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    void'($urandom(32'h45dc));
    repeat (20) @(negedge sys_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge link_clk);
    run = 1'b1;
    check("sidetone", 16'h0042, {7'h0, st});
    rd(AST_ADDR_SIDETONE, 16'had00);
    rd(AST_ADDR_EXT_AUDIO, 16'h0000);
    rd(AST_ADDR_PLAY_RATE, 16'hbb80);
    rd(AST_ADDR_AUX_RATE, 16'hbb80);
    rd(AST_ADDR_REC_RATE, 16'hbb80);
    rd(7'h7e, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom());
      w[11:10] = 2'(i);
      wr(AST_ADDR_SIDETONE, w);
      check("sidetone", {7'h0, ~w[15], w[14:12], ~w[10], ~w[11], w[9:7]}, {7'h0, st});
      rd(AST_ADDR_SIDETONE, w & 16'hff80);
    end
    foreach (maddr[i]) begin
      w = 16'($urandom());
      wr(maddr[i], w);
      check("mixer", w, mix[i]);
      rd(maddr[i], w);
    end
    $display("sidetone and mixer test done");
    @(negedge sys_clk_i);
    {dac_en, adc_en, aux_en} = 3'b111;
    wr(AST_ADDR_PLAY_RATE, 16'h1f40);
    check("play rate", 16'hbb80, play_rate);
    wr(AST_ADDR_EXT_AUDIO, 16'hffff);
    rd(AST_ADDR_EXT_AUDIO, 16'h0001);
    for (int i = 0; i < 12; i++) begin
      w = (i < 9) ? AST_RATES[i] : 16'($urandom());
      wr(AST_ADDR_PLAY_RATE, w);
      check("play rate", near(w), play_rate);
      rd(AST_ADDR_PLAY_RATE, w);
    end
    $display("playback rate test done");
    @(negedge sys_clk_i);
    adc_en = 1'b0;
    wr(AST_ADDR_REC_RATE, 16'h1f40);
    @(negedge sys_clk_i);
    adc_en = 1'b1;
    rd(AST_ADDR_REC_RATE, 16'hbb80);
    check("rec rate", 16'hbb80, rec_rate);
    wr(AST_ADDR_PLAY_RATE, 16'h1f40);
    wr(AST_ADDR_REC_RATE, 16'h3e80);
    wr(AST_ADDR_AUX_RATE, 16'h7d00);
    check("aux rate", 16'h7d00, aux_rate);
    check("play rate", 16'h1f40, play_rate);
    check("rec rate", 16'h3e80, rec_rate);
    tags(60, 10, 20, 40);
    @(negedge sys_clk_i);
    dac_en = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    check("play rate", 16'hbb80, play_rate);
    wr(AST_ADDR_EXT_AUDIO, 16'h0000);
    check("rec rate", 16'hbb80, rec_rate);
    check("aux rate", 16'hbb80, aux_rate);
    tags(12, 12, 12, 12);
    check("pending reads", 16'h0000, 16'(exp_q.size()));
    $display("rate and frame test done");
    stop_test();
  end
endmodule
bind ast_audio_rate_sidetone_ctrl ast_ctrl_checker chk (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .link_clk_i(link_clk_i), .link_frame_i(link_frame_i),
  .link_aux_valid_o(link_aux_valid_o), .dac_enable_i(dac_enable_i),
  .adc_enable_i(adc_enable_i), .sidetone_o(sidetone_o), .play_rate_o(play_rate_o),
  .rec_rate_o(rec_rate_o), .aux_rate_o(aux_rate_o));
